/* File: thos_output_select.sv */
// register file, axis conditioning and output selection for tilt and heading results
`timescale 1ns/10ps
`include "thos_defines.svh"

// Operation
// - view clear: offset regs show gyro data
// - view set: offset regs show estimates, correct gyro
// - enable bit gates computation, default off
// - exchange X and Y magnetic axes
// - invert X, Y after exchange
// - invert Z magnetic axis
// - tilt select chooses accel or filtered angles
// - accel angles as wrapping signed words
// - filtered angles two's complement, gyro scale
// - offset words two's complement, view dependent
// - heading ten bits unsigned, right aligned
module thos_output_select #(
  parameter int ADDR_W = 10
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic [ADDR_W-1:0]         avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire thos_pkg::thos_update_type update,
  input  wire thos_pkg::thos_mag_type    mag_raw,
  output thos_pkg::thos_mag_type         mag_cond,
  output logic                           compute_enable,
  output logic      [15:0]               gyro_x_correction,
  output logic      [15:0]               gyro_y_correction
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must cover word index 0xD5 at byte address 4*index");
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0]                mag_cfg_q;
  logic [7:0]                ofs_view_q;
  thos_pkg::thos_ctrl_type   ctrl;
  thos_pkg::thos_result_type result_q;
  thos_pkg::thos_bus_state_type bus_state_q;
  logic [7:0]                word_idx;
  logic                      wr_hit_cfg;
  logic                      wr_hit_view;

  assign word_idx    = avs_address[9:2];
  assign wr_hit_cfg  = avs_write && avs_byteenable[0] && (word_idx == `THOS_IDX_MAG_CFG);
  assign wr_hit_view = avs_write && avs_byteenable[0] && (word_idx == `THOS_IDX_OFS_VIEW);

  // the write takes effect at the edge where waitrequest is low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mag_cfg_q <= `THOS_MAG_CFG_RESET;
    end else if (wr_hit_cfg && !avs_waitrequest) begin
      mag_cfg_q <= avs_writedata[7:0] & `THOS_MAG_CFG_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ofs_view_q <= `THOS_OFS_VIEW_RESET;
    end else if (wr_hit_view && !avs_waitrequest) begin
      // only the select bit is kept; the fixed ones always read back
      ofs_view_q <= (avs_writedata[7:0] & (8'h01 << `THOS_BIT_OFS_VIEW)) | `THOS_OFS_VIEW_FIXED;
    end
  end

  always_comb begin
    ctrl.enable      = mag_cfg_q[`THOS_BIT_ENABLE];
    ctrl.xy_exchange = mag_cfg_q[`THOS_BIT_XY_EXCHANGE];
    ctrl.x_invert    = mag_cfg_q[`THOS_BIT_X_INVERT];
    ctrl.y_invert    = mag_cfg_q[`THOS_BIT_Y_INVERT];
    ctrl.z_invert    = mag_cfg_q[`THOS_BIT_Z_INVERT];
    ctrl.tilt_source = mag_cfg_q[`THOS_BIT_TILT_SRC];
    ctrl.offset_view = ofs_view_q[`THOS_BIT_OFS_VIEW];
  end

  assign compute_enable = ctrl.enable;

  // ****************************************
  // magnetic axis conditioning
  // ****************************************
  logic [15:0] mag_x_ex;
  logic [15:0] mag_y_ex;

  assign mag_x_ex = ctrl.xy_exchange ? mag_raw.y : mag_raw.x;
  assign mag_y_ex = ctrl.xy_exchange ? mag_raw.x : mag_raw.y;

  // registered so the heading engine sees one consistent axis set per cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mag_cond <= '0;
    end else begin
      mag_cond.x <= ctrl.x_invert ? 16'(-mag_x_ex) : mag_x_ex;
      mag_cond.y <= ctrl.y_invert ? 16'(-mag_y_ex) : mag_y_ex;
      mag_cond.z <= ctrl.z_invert ? 16'(-mag_raw.z) : mag_raw.z;
    end
  end

  // ****************************************
  // gyro correction
  // ****************************************
  // estimates correct gyro only in estimate view
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gyro_x_correction <= `THOS_WORD_ZERO;
      gyro_y_correction <= `THOS_WORD_ZERO;
    end else if (update.valid && ctrl.enable) begin
      gyro_x_correction <= ctrl.offset_view ? update.est_ofs_pitch : `THOS_WORD_ZERO;
      gyro_y_correction <= ctrl.offset_view ? update.est_ofs_roll : `THOS_WORD_ZERO;
    end
  end

  // ****************************************
  // result capture
  // ****************************************
  // all words latched together from one update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (update.valid && ctrl.enable) begin
      // angle source; and words pass unaltered
      result_q.pitch     <= ctrl.tilt_source ? update.filter_pitch : update.accel_pitch;
      result_q.roll      <= ctrl.tilt_source ? update.filter_roll : update.accel_roll;
      result_q.pitch_ofs <= ctrl.offset_view ? update.est_ofs_pitch : update.gyro_pitch;
      result_q.roll_ofs  <= ctrl.offset_view ? update.est_ofs_roll : update.gyro_roll;
      // heading right aligned, upper bits zero
      result_q.heading   <= {{(16-`THOS_HEADING_BITS){1'b0}}, update.heading[`THOS_HEADING_BITS-1:0]};
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  // high byte of each pair is read from a snapshot taken with the low byte,
  // so a low-then-high read pair never mixes two updates
  thos_pkg::thos_result_type snap_q;
  logic [7:0]                rd_byte;
  logic                      rd_low;

  always_comb begin
    rd_low  = 1'b0;
    rd_byte = `THOS_BYTE_ZERO;
    unique case (word_idx)
      `THOS_IDX_OFS_VIEW: rd_byte = ofs_view_q;
      `THOS_IDX_MAG_CFG:  rd_byte = mag_cfg_q;
      `THOS_IDX_PITCH_L: begin
        rd_byte = result_q.pitch[7:0];
        rd_low  = 1'b1;
      end
      `THOS_IDX_PITCH_H:  rd_byte = snap_q.pitch[15:8];
      `THOS_IDX_ROLL_L: begin
        rd_byte = result_q.roll[7:0];
        rd_low  = 1'b1;
      end
      `THOS_IDX_ROLL_H:   rd_byte = snap_q.roll[15:8];
      `THOS_IDX_POFS_L: begin
        rd_byte = result_q.pitch_ofs[7:0];
        rd_low  = 1'b1;
      end
      `THOS_IDX_POFS_H:   rd_byte = snap_q.pitch_ofs[15:8];
      `THOS_IDX_ROFS_L: begin
        rd_byte = result_q.roll_ofs[7:0];
        rd_low  = 1'b1;
      end
      `THOS_IDX_ROFS_H:   rd_byte = snap_q.roll_ofs[15:8];
      `THOS_IDX_HEAD_L: begin
        rd_byte = result_q.heading[7:0];
        rd_low  = 1'b1;
      end
      `THOS_IDX_HEAD_H:   rd_byte = snap_q.heading[15:8];
      default:            rd_byte = `THOS_BYTE_ZERO;
    endcase
  end

  // one wait cycle: requests are taken in IDLE, answered in REPLY
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_state_q <= thos_pkg::THOS_IDLE;
    end else begin
      unique case (bus_state_q)
        thos_pkg::THOS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_q <= thos_pkg::THOS_REPLY;
          end
        end
        thos_pkg::THOS_REPLY: bus_state_q <= thos_pkg::THOS_IDLE;
        default:              bus_state_q <= thos_pkg::THOS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_state_q != thos_pkg::THOS_REPLY);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (avs_read && bus_state_q == thos_pkg::THOS_IDLE) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      snap_q <= '0;
    end else if (avs_read && rd_low && bus_state_q == thos_pkg::THOS_IDLE) begin
      snap_q <= result_q;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_cfg_reset_off: assert property (@(posedge clk_sys) $rose(rst_n) |-> !compute_enable)
    else $error("enable not off after reset");

  a_freeze_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl.enable |=> $stable(result_q) && $stable(gyro_x_correction) && $stable(gyro_y_correction))
    else $error("results changed while computation off");

  a_view_gyro_pitch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && !ctrl.offset_view) |=> result_q.pitch_ofs == $past(update.gyro_pitch))
    else $error("pitch offset not gyro data");

  a_view_gyro_roll: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && !ctrl.offset_view) |=> result_q.roll_ofs == $past(update.gyro_roll))
    else $error("roll offset not gyro data");

  a_gyro_view_nocorr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && !ctrl.offset_view) |=> gyro_x_correction == '0 && gyro_y_correction == '0)
    else $error("correction applied in gyro view");

  a_view_est_roll: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && ctrl.offset_view) |=>
      result_q.roll_ofs == $past(update.est_ofs_roll) && gyro_y_correction == $past(update.est_ofs_roll))
    else $error("roll estimate not shown or applied");

  a_view_est_pitch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && ctrl.offset_view) |=>
      result_q.pitch_ofs == $past(update.est_ofs_pitch) && gyro_x_correction == $past(update.est_ofs_pitch))
    else $error("pitch estimate not shown or applied");

  a_swap_x_axis: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.xy_exchange && !ctrl.x_invert) |=> mag_cond.x == $past(mag_raw.y))
    else $error("x axis not exchanged");

  a_swap_y_axis: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.xy_exchange && !ctrl.y_invert) |=> mag_cond.y == $past(mag_raw.x))
    else $error("y axis not exchanged");

  a_keep_x_axis: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ctrl.xy_exchange && !ctrl.x_invert) |=> mag_cond.x == $past(mag_raw.x))
    else $error("x axis changed without exchange");

  a_invert_x_after: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.xy_exchange && ctrl.x_invert) |=> mag_cond.x == 16'(-$past(mag_raw.y)))
    else $error("x inversion not after exchange");

  a_invert_y_after: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.xy_exchange && ctrl.y_invert) |=> mag_cond.y == 16'(-$past(mag_raw.x)))
    else $error("y inversion not after exchange");

  a_invert_z_axis: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl.z_invert |=> mag_cond.z == 16'(-$past(mag_raw.z)))
    else $error("z not inverted");

  a_keep_z_axis: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl.z_invert |=> mag_cond.z == $past(mag_raw.z))
    else $error("z changed without inversion");

  a_tilt_src_accel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && !ctrl.tilt_source) |=> result_q.roll == $past(update.accel_roll))
    else $error("roll not from accelerometer");

  a_accel_pitch_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && !ctrl.tilt_source) |=> result_q.pitch == $past(update.accel_pitch))
    else $error("pitch not accelerometer word");

  a_tilt_src_filter: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && ctrl.tilt_source) |=> result_q.pitch == $past(update.filter_pitch))
    else $error("pitch not filtered angle");

  a_filter_roll_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable && ctrl.tilt_source) |=> result_q.roll == $past(update.filter_roll))
    else $error("roll not filtered angle");

  a_heading_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
    result_q.heading[15:`THOS_HEADING_BITS] == '0)
    else $error("heading upper bits not zero");

  a_heading_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (update.valid && ctrl.enable) |=>
      result_q.heading[`THOS_HEADING_BITS-1:0] == $past(update.heading[`THOS_HEADING_BITS-1:0]))
    else $error("heading bits not taken from update");

  a_snap_on_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read && rd_low && bus_state_q == thos_pkg::THOS_IDLE) |=> snap_q == $past(result_q))
    else $error("snapshot not taken with low byte");

  a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read && bus_state_q == thos_pkg::THOS_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait");

endmodule

/* File: thos_defines.svh */
// register offsets, field positions and reset values of the tilt and heading output block
`ifndef THOS_DEFINES_SVH
`define THOS_DEFINES_SVH

// register indices; the bus byte address of each register is 4 * index
`define THOS_IDX_OFS_VIEW    8'hC9
`define THOS_IDX_MAG_CFG     8'hCA
`define THOS_IDX_PITCH_L     8'hCC
`define THOS_IDX_PITCH_H     8'hCD
`define THOS_IDX_ROLL_L      8'hCE
`define THOS_IDX_ROLL_H      8'hCF
`define THOS_IDX_POFS_L      8'hD0
`define THOS_IDX_POFS_H      8'hD1
`define THOS_IDX_ROFS_L      8'hD2
`define THOS_IDX_ROFS_H      8'hD3
`define THOS_IDX_HEAD_L      8'hD4
`define THOS_IDX_HEAD_H      8'hD5

// magnetic_axis_config fields
`define THOS_BIT_ENABLE      7
`define THOS_BIT_RSVD6       6
`define THOS_BIT_XY_EXCHANGE 5
`define THOS_BIT_X_INVERT    4
`define THOS_BIT_Y_INVERT    3
`define THOS_BIT_Z_INVERT    2
`define THOS_BIT_TILT_SRC    1
`define THOS_BIT_RSVD0       0
`define THOS_MAG_CFG_RESET   8'h00
`define THOS_MAG_CFG_WMASK   8'hBE

// offset view register: bit 6 selects, bits 5 and 1 read back as ones
`define THOS_BIT_OFS_VIEW    6
`define THOS_OFS_VIEW_RESET  8'h22
`define THOS_OFS_VIEW_FIXED  8'h22

`define THOS_HEADING_BITS    10
`define THOS_WORD_ZERO       16'h0000
`define THOS_BYTE_ZERO       8'h00
`define THOS_READ_LATENCY    1

`endif

/* File: thos_pkg.sv */
// types shared by the tilt and heading output block
package thos_pkg;

  typedef struct packed {
    logic        enable;
    logic        xy_exchange;
    logic        x_invert;
    logic        y_invert;
    logic        z_invert;
    logic        tilt_source;
    logic        offset_view;
  } thos_ctrl_type;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } thos_mag_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] accel_pitch;
    logic [15:0] accel_roll;
    logic [15:0] filter_pitch;
    logic [15:0] filter_roll;
    logic [15:0] gyro_pitch;
    logic [15:0] gyro_roll;
    logic [15:0] est_ofs_pitch;
    logic [15:0] est_ofs_roll;
    logic [15:0] heading;
  } thos_update_type;

  typedef struct packed {
    logic [15:0] pitch;
    logic [15:0] roll;
    logic [15:0] pitch_ofs;
    logic [15:0] roll_ofs;
    logic [15:0] heading;
  } thos_result_type;

  typedef enum logic [1:0] {
    THOS_IDLE  = 2'b00,
    THOS_REPLY = 2'b01
  } thos_bus_state_type;

endpackage

/* File: thos_testbench.sv */
// self-checking bench for the tilt and heading output block
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [7:0]             cfg;
    logic                   view;
    thos_pkg::thos_mag_type cond;
  } thos_tb_row_type;
  logic                      clk_sys;
  logic                      rst_n;
  logic [9:0]                avs_address;
  logic                      avs_read;
  logic                      avs_write;
  logic [31:0]               avs_writedata;
  logic [3:0]                avs_byteenable;
  logic [31:0]               avs_readdata;
  logic                      avs_waitrequest;
  thos_pkg::thos_update_type update;
  thos_pkg::thos_mag_type    mag_raw;
  thos_pkg::thos_mag_type    mag_cond;
  logic                      compute_enable;
  logic [15:0]               gyro_x_correction;
  logic [15:0]               gyro_y_correction;
  logic [31:0]               rd;
  logic [7:0]                k;
  logic [15:0]               ew;
  int                        n_errors = 0;
  int                        n_compared = 0;
  int                        cycles = 0;
  // raw axes fixed at x=1234 y=0f0f z=8001; rows give the conditioned result
  thos_tb_row_type           rows [7] = '{
    '{8'h80, 1'b0, '{16'h1234, 16'h0f0f, 16'h8001}},
    '{8'ha0, 1'b1, '{16'h0f0f, 16'h1234, 16'h8001}},
    '{8'hb0, 1'b0, '{16'hf0f1, 16'h1234, 16'h8001}},
    '{8'ha8, 1'b1, '{16'h0f0f, 16'hedcc, 16'h8001}},
    '{8'h84, 1'b0, '{16'h1234, 16'h0f0f, 16'h7fff}},
    '{8'h9e, 1'b1, '{16'hedcc, 16'hf0f1, 16'h7fff}},
    '{8'h82, 1'b0, '{16'h1234, 16'h0f0f, 16'h8001}}};

  thos_output_select thos_output_select_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .update(update),
    .mag_raw(mag_raw), .mag_cond(mag_cond), .compute_enable(compute_enable),
    .gyro_x_correction(gyro_x_correction), .gyro_y_correction(gyro_y_correction));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected read data at %0t: %h not %h", $time, got, exp);
    end
  endtask

  task check_w(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected output at %0t: %h not %h", $time, got, exp);
    end
  endtask

  task check_mag(input thos_pkg::thos_mag_type got, input thos_pkg::thos_mag_type exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected axes at %0t: %h not %h", $time, got, exp);
    end
  endtask

  // request raised after an edge, held until the edge that samples waitrequest low; data taken at that edge
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    check_rd(rd, {24'h00_0000, exp});
  endtask

  function automatic thos_pkg::thos_update_type mk(input logic [7:0] kk);
    thos_pkg::thos_update_type u;
    logic [15:0]               w;
    w = {kk, ~kk};
    u.valid = 1'b1;
    u.accel_pitch = w ^ 16'ha001;
    u.accel_roll = w ^ 16'ha002;
    u.filter_pitch = w ^ 16'hf001;
    u.filter_roll = w ^ 16'hf002;
    u.gyro_pitch = w ^ 16'h6001;
    u.gyro_roll = w ^ 16'h6002;
    u.est_ofs_pitch = w ^ 16'he001;
    u.est_ofs_roll = w ^ 16'he002;
    u.heading = w;
    return u;
  endfunction

  // word j of the result block: pitch, roll, pitch offset, roll offset, heading
  function automatic logic [15:0] exp_word(input int j, input logic [7:0] kk, input logic [7:0] cfg, input logic view);
    thos_pkg::thos_update_type u;
    u = mk(kk);
    case (j)
      0: return cfg[1] ? u.filter_pitch : u.accel_pitch;
      1: return cfg[1] ? u.filter_roll : u.accel_roll;
      2: return view ? u.est_ofs_pitch : u.gyro_pitch;
      3: return view ? u.est_ofs_roll : u.gyro_roll;
      default: return {6'h00, u.heading[9:0]};
    endcase
  endfunction

  task push(input logic [7:0] kk);
    @(posedge clk_sys);
    update <= mk(kk);
    @(posedge clk_sys);
    update.valid <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    update = '0;
    mag_raw = '{16'h1234, 16'h0f0f, 16'h8001};
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check_mag(mag_cond, '0);
    check_w({gyro_x_correction[14:0], compute_enable}, 16'h0000);
    check_w(gyro_y_correction, 16'h0000);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(8'hca, 8'h00);
    rdchk(8'hc9, 8'h22);
    rdchk(8'hd5, 8'h00);
    for (int i = 0; i < 7; i++) begin
      k = 8'(i * 16 + 5);
      bus(1'b1, 8'hca, rows[i].cfg, 4'h1);
      bus(1'b1, 8'hc9, rows[i].view ? 8'h62 : 8'h22, 4'h1);
      push(k);
      @(negedge clk_sys);
      check_mag(mag_cond, rows[i].cond);
      check_w({15'h0000, compute_enable}, 16'h0001);
      check_w(gyro_x_correction, rows[i].view ? mk(k).est_ofs_pitch : 16'h0000);
      check_w(gyro_y_correction, rows[i].view ? mk(k).est_ofs_roll : 16'h0000);
      rdchk(8'hca, rows[i].cfg);
      for (int j = 0; j < 5; j++) begin
        ew = exp_word(j, k, rows[i].cfg, rows[i].view);
        rdchk(8'(8'hcc + 2 * j), ew[7:0]);
        rdchk(8'(8'hcd + 2 * j), ew[15:8]);
      end
    end
    // an update between the two byte reads must not tear the word
    push(8'h31);
    ew = exp_word(0, 8'h31, 8'h82, 1'b0);
    rdchk(8'hcc, ew[7:0]);
    push(8'h32);
    rdchk(8'hcd, ew[15:8]);
    ew = exp_word(0, 8'h32, 8'h82, 1'b0);
    rdchk(8'hcc, ew[7:0]);
    bus(1'b1, 8'hca, 8'h02, 4'h1);
    push(8'h40);
    check_w({15'h0000, compute_enable}, 16'h0000);
    rdchk(8'hcc, ew[7:0]);
    bus(1'b1, 8'hcc, 8'h55, 4'h1);
    rdchk(8'hcc, ew[7:0]);
    // all six writable bits read back; a write without byte 0 enabled is ignored
    bus(1'b1, 8'hca, 8'hbe, 4'hf);
    rdchk(8'hca, 8'hbe);
    bus(1'b1, 8'hca, 8'h00, 4'he);
    rdchk(8'hca, 8'hbe);
    rdchk(8'hc0, 8'h00);
    // second reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(8'hca, 8'h00);
    rdchk(8'hc9, 8'h22);
    rdchk(8'hcc, 8'h00);
    complete_run();
  end
endmodule
